// ===== br4_defs.vh
// Constants for the buck regulator four configuration register bank.
// Assumes inclusion by br4_config_regs.v only; definitions only.
`ifndef BR4_DEFS_VH
`define BR4_DEFS_VH

// Register byte addresses
`define BR4_ADDR_NORMAL   8'h4a
`define BR4_ADDR_STANDBY  8'h4b
`define BR4_ADDR_SLEEP    8'h4c
`define BR4_ADDR_MODE     8'h4d
`define BR4_ADDR_TUNING   8'h4e

// Field positions
`define BR4_CODE_MSB      5
`define BR4_RANGE_BIT     6
`define BR4_MODE_MSB      3
`define BR4_SLEEP_BHV_BIT 5
`define BR4_ILIM_BIT      0
`define BR4_SPARE_BIT     1
`define BR4_FREQ_LSB      2
`define BR4_PHASE_LSB     4
`define BR4_DVS_LSB       6

// Reset values
`define BR4_CODE_RST      6'h00
`define BR4_MODE_RST      4'h0
`define BR4_TUNING_RST    8'h00

// Power states of the device
`define BR4_PS_NORMAL     2'h0
`define BR4_PS_STANDBY    2'h1
`define BR4_PS_SLEEP      2'h2

// Set point decode, in units of 0.1 mV
`define BR4_LOW_BASE      16'h0fa0
`define BR4_LOW_STEP      16'h00fa
`define BR4_HIGH_BASE     16'h1f40
`define BR4_HIGH_STEP     16'h01f4
`define BR4_HIGH_LAST     6'h32

`endif

// ===== br4_config_regs.v
// Configuration register bank of buck regulator four.
// Assumes a serial control bus slave on sys_clk that issues single-cycle
// read and write strobes, and power state and fuse logic on sys_clk.
`timescale 1ns/1ps
`default_nettype none
`include "br4_defs.vh"

// What this block does
// - Five registers sit at byte addresses 0x4A to 0x4E in order.
// - Normal set point bits 5:0 are read/write, reset zero.
// - Normal bit 6 is read-only range, loaded only from fuse config.
// - Standby set point bits 5:0 are read/write, reset zero.
// - Standby bit 6 mirrors the configured range bit, read-only.
// - Sleep set point bits 5:0 are read/write, reset zero.
// - Sleep bit 6 mirrors the configured range bit, read-only.
// - Mode register bits 3:0 select the normal switching mode.
// - Mode bit 5 picks sleep behaviour: 0 off, 1 pulse-frequency.
// - Tuning bit 0 picks current limit: 0 high, 1 low.
// - Tuning bits 3:2 select switching frequency, reset zero.
// - Tuning bits 5:4 select phase clock, reset zero.
// - Tuning bits 7:6 select voltage scaling speed, reset zero.
// - Setup and control go through these registers, except range from fuse config and power_state.
// - Range bit and six code bits decode to an output voltage.
module br4_config_regs
(
  input  wire        sys_clk,
  input  wire        reset,
  input  wire [7:0]  reg_addr,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  output reg         reg_rvalid,
  output wire        reg_hit,
  input  wire        fuse_range_load,
  input  wire        fuse_range_value,
  input  wire [1:0]  power_state,
  output reg  [6:0]  active_setpoint,
  output reg  [15:0] active_voltage,
  output reg         setpoint_reserved,
  output reg         regulator_enable,
  output reg         pfm_force,
  output reg  [3:0]  switching_mode,
  output reg         current_limit_low,
  output reg  [1:0]  switching_frequency_select,
  output reg  [1:0]  phase_clock_select,
  output reg  [1:0]  voltage_scaling_speed
);

  // Stored fields
  wire [5:0] normal_code_ff;
  wire [5:0] standby_code_ff;
  wire [5:0] sleep_code_ff;
  reg        range_ff;
  reg  [3:0] mode_ff;
  reg        sleep_bhv_ff;
  reg  [7:0] tuning_ff;

  // Next values
  reg        nxt_range;
  reg  [3:0] nxt_mode;
  reg        nxt_sleep_bhv;
  reg  [7:0] nxt_tuning;

  // Decode helpers
  wire       sel_normal;
  wire       sel_standby;
  wire       sel_sleep;
  wire       sel_mode;
  wire       sel_tuning;
  reg  [7:0] rd_mux;
  reg  [5:0] pick_code;
  reg  [15:0] pick_voltage;
  reg        pick_reserved;

  // Address decode
  assign sel_normal  = (reg_addr == `BR4_ADDR_NORMAL);
  assign sel_standby = (reg_addr == `BR4_ADDR_STANDBY);
  assign sel_sleep   = (reg_addr == `BR4_ADDR_SLEEP);
  assign sel_mode    = (reg_addr == `BR4_ADDR_MODE);
  assign sel_tuning  = (reg_addr == `BR4_ADDR_TUNING);
  assign reg_hit     = sel_normal | sel_standby | sel_sleep |
                       sel_mode | sel_tuning;

  // Normal set point code
  br4_code_reg
  #(
    .WIDTH   (6)
  )
  u_normal_code
  (
    .sys_clk (sys_clk),
    .reset   (reset),
    .wr_en   (reg_wr & sel_normal),
    .wdata   (reg_wdata[`BR4_CODE_MSB:0]),
    .code_ff (normal_code_ff)
  );

  // Standby set point code
  br4_code_reg
  #(
    .WIDTH   (6)
  )
  u_standby_code
  (
    .sys_clk (sys_clk),
    .reset   (reset),
    .wr_en   (reg_wr & sel_standby),
    .wdata   (reg_wdata[`BR4_CODE_MSB:0]),
    .code_ff (standby_code_ff)
  );

  // Sleep set point code
  br4_code_reg
  #(
    .WIDTH   (6)
  )
  u_sleep_code
  (
    .sys_clk (sys_clk),
    .reset   (reset),
    .wr_en   (reg_wr & sel_sleep),
    .wdata   (reg_wdata[`BR4_CODE_MSB:0]),
    .code_ff (sleep_code_ff)
  );

  // Write path; only writable fields take bus data
  always @*
  begin
    nxt_range        = range_ff;
    nxt_mode         = mode_ff;
    nxt_sleep_bhv    = sleep_bhv_ff;
    nxt_tuning       = tuning_ff;
    if (reg_wr)
    begin
      if (sel_mode)
      begin
        nxt_mode      = reg_wdata[`BR4_MODE_MSB:0];
        nxt_sleep_bhv = reg_wdata[`BR4_SLEEP_BHV_BIT];
      end
      if (sel_tuning)
      begin
        nxt_tuning = reg_wdata;
      end
    end
    // Range bit comes from fuse or prototype configuration only
    if (fuse_range_load)
    begin
      nxt_range = fuse_range_value;
    end
  end

  // Register state
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      range_ff        <= 1'b0;
      mode_ff         <= `BR4_MODE_RST;
      sleep_bhv_ff    <= 1'b0;
      tuning_ff       <= `BR4_TUNING_RST;
    end
    else
    begin
      range_ff        <= nxt_range;
      mode_ff         <= nxt_mode;
      sleep_bhv_ff    <= nxt_sleep_bhv;
      tuning_ff       <= nxt_tuning;
    end
  end

  // Read mux; unused bits and unmapped addresses read zero, except tuning spare bit 1, which reads back as written
  always @*
  begin
    rd_mux = 8'h00;
    case (1'b1)
      sel_normal:
        rd_mux = {1'b0, range_ff, normal_code_ff};
      sel_standby:
        rd_mux = {1'b0, range_ff, standby_code_ff};
      sel_sleep:
        rd_mux = {1'b0, range_ff, sleep_code_ff};
      sel_mode:
        rd_mux = {2'b00, sleep_bhv_ff, 1'b0, mode_ff};
      sel_tuning:
        rd_mux = tuning_ff;
      default:
        rd_mux = 8'h00;
    endcase
  end

  // Read data is registered one cycle after the strobe
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
      begin
        reg_rdata <= rd_mux;
      end
    end
  end

  // Choose the set point for the present power state
  always @*
  begin
    case (power_state)
      `BR4_PS_STANDBY:
        pick_code = standby_code_ff;
      `BR4_PS_SLEEP:
        pick_code = sleep_code_ff;
      default:
        pick_code = normal_code_ff;
    endcase
  end

  // Seven-bit set point to voltage in 0.1 mV units
  always @*
  begin
    pick_reserved = 1'b0;
    if (range_ff)
    begin
      pick_voltage = `BR4_HIGH_BASE +
                     {10'h000, pick_code} * `BR4_HIGH_STEP;
      pick_reserved = (pick_code > `BR4_HIGH_LAST);
    end
    else
    begin
      pick_voltage = `BR4_LOW_BASE +
                     {10'h000, pick_code} * `BR4_LOW_STEP;
    end
  end

  // Control outputs registered from register contents and power_state
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      active_setpoint            <= 7'h00;
      active_voltage             <= `BR4_LOW_BASE;
      setpoint_reserved          <= 1'b0;
      regulator_enable           <= 1'b1;
      pfm_force                  <= 1'b0;
      switching_mode             <= `BR4_MODE_RST;
      current_limit_low          <= 1'b0;
      switching_frequency_select <= 2'h0;
      phase_clock_select         <= 2'h0;
      voltage_scaling_speed      <= 2'h0;
    end
    else
    begin
      active_setpoint   <= {range_ff, pick_code};
      active_voltage    <= pick_voltage;
      setpoint_reserved <= pick_reserved;
      // Sleep turns the regulator off unless pulse-frequency is chosen
      regulator_enable  <= (power_state != `BR4_PS_SLEEP) |
                           sleep_bhv_ff;
      pfm_force         <= (power_state == `BR4_PS_SLEEP) &
                           sleep_bhv_ff;
      switching_mode    <= mode_ff;
      current_limit_low <= tuning_ff[`BR4_ILIM_BIT];
      switching_frequency_select <=
        tuning_ff[`BR4_FREQ_LSB+1:`BR4_FREQ_LSB];
      phase_clock_select <=
        tuning_ff[`BR4_PHASE_LSB+1:`BR4_PHASE_LSB];
      voltage_scaling_speed <=
        tuning_ff[`BR4_DVS_LSB+1:`BR4_DVS_LSB];
    end
  end

endmodule // br4_config_regs

// Holds one set point code; written only on its own strobe
module br4_code_reg
#(
  parameter WIDTH = 6
)
(
  input  wire             sys_clk,
  input  wire             reset,
  input  wire             wr_en,
  input  wire [WIDTH-1:0] wdata,
  output reg  [WIDTH-1:0] code_ff
);

  reg  [WIDTH-1:0] nxt_code;

  // Hold unless this register is addressed by a write
  always @*
  begin
    nxt_code = code_ff;
    if (wr_en)
    begin
      nxt_code = wdata;
    end
  end

  // Register state
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      code_ff <= `BR4_CODE_RST;
    end
    else
    begin
      code_ff <= nxt_code;
    end
  end

endmodule // br4_code_reg
`default_nettype wire

// ===== br4_config_regs_assertions.sv
// Port assertions for the regulator register bank.
// Assumes binding onto br4_config_regs.
`timescale 1ns/1ps
`default_nettype none
module br4_cfg_assertions
(
  input wire logic       sys_clk,
  input wire logic       reset,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid,
  input wire logic       reg_hit,
  input wire logic [1:0] power_state,
  input wire logic       regulator_enable,
  input wire logic       pfm_force
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  property p_rv; reg_rd |=> reg_rvalid; endproperty
  a_rv: assert property (p_rv) else $error("read gave no valid");
  property p_norv; !reg_rd |=> !reg_rvalid; endproperty
  a_norv: assert property (p_norv) else $error("stray valid");
  property p_hit;
    reg_hit == (reg_addr >= 8'h4a && reg_addr <= 8'h4e);
  endproperty
  a_hit: assert property (p_hit) else $error("bad decode");
  property p_unmap; reg_rd && !reg_hit |=> reg_rdata == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped data");
  property p_b7; reg_rd && reg_addr != 8'h4e |=> !reg_rdata[7]; endproperty
  a_b7: assert property (p_b7) else $error("unused bit 7 set");
  property p_mode;
    reg_rd && reg_addr == 8'h4d |=> reg_rdata[7:6] == 2'h0 && !reg_rdata[4];
  endproperty
  a_mode: assert property (p_mode) else $error("mode unused set");
  property p_hold; !reg_rd |=> $stable(reg_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_norm; power_state != 2'h2 |=> regulator_enable && !pfm_force;
  endproperty
  a_norm: assert property (p_norm) else $error("awake but off");
  property p_slp; power_state == 2'h2 |=> regulator_enable == pfm_force;
  endproperty
  a_slp: assert property (p_slp) else $error("sleep mix");
endmodule // br4_cfg_assertions
bind br4_config_regs br4_cfg_assertions u_chk (.sys_clk(sys_clk),
  .reset(reset), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_hit(reg_hit),
  .power_state(power_state), .regulator_enable(regulator_enable),
  .pfm_force(pfm_force));
`default_nettype wire

// ===== br4_host.sv
// Host model driving the register strobe port.
// Assumes requests change at the falling edge of sys_clk.
`timescale 1ns/1ps
`default_nettype none
module br4_host
(
  input  wire logic       sys_clk,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid,
  output var  logic [7:0] reg_addr,
  output var  logic       reg_wr,
  output var  logic       reg_rd,
  output var  logic [7:0] reg_wdata
);
  initial
  begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // One-cycle write; released bus shows inverted values
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
    reg_addr = ~a;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q,
                    output logic ok);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    ok = reg_rvalid;
    q = reg_rdata;
  endtask
endmodule // br4_host
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the regulator register bank.
// Assumes br4_host on the strobe port and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic        fuse_range_load = 1'b0;
  logic        fuse_range_value = 1'b0;
  logic [1:0]  power_state = 2'h0;
  wire  [7:0]  reg_addr, reg_wdata, reg_rdata;
  wire         reg_wr, reg_rd, reg_rvalid, reg_hit, setpoint_reserved;
  wire         regulator_enable, pfm_force, current_limit_low;
  wire  [6:0]  active_setpoint;
  wire  [15:0] active_voltage;
  wire  [3:0]  switching_mode;
  wire  [1:0]  switching_frequency_select, phase_clock_select;
  wire  [1:0]  voltage_scaling_speed;
  int          err_total = 0;
  int          checks = 0;
  always #2 sys_clk = ~sys_clk;
  br4_config_regs uut (.sys_clk(sys_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .reg_hit(reg_hit), .fuse_range_load(fuse_range_load),
    .fuse_range_value(fuse_range_value), .power_state(power_state),
    .active_setpoint(active_setpoint), .active_voltage(active_voltage),
    .setpoint_reserved(setpoint_reserved),
    .regulator_enable(regulator_enable), .pfm_force(pfm_force),
    .switching_mode(switching_mode), .current_limit_low(current_limit_low),
    .switching_frequency_select(switching_frequency_select),
    .phase_clock_select(phase_clock_select),
    .voltage_scaling_speed(voltage_scaling_speed));
  br4_host host (.sys_clk(sys_clk), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata));
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    logic       ok;
    host.rd(a, q, ok);
    cmp({15'h0000, ok}, 16'h0001);
    cmp({8'h00, q}, {8'h00, e});
  endtask
  task automatic t_reset;
    rchk(8'h4a, 8'h00);
    rchk(8'h4b, 8'h00);
    rchk(8'h4c, 8'h00);
    rchk(8'h4d, 8'h00);
    rchk(8'h4e, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_mask;
    for (int i = 0; i < 6; i++) host.wr(8'h4a + i[7:0], 8'hff);
    rchk(8'h4a, 8'h3f);
    rchk(8'h4b, 8'h3f);
    rchk(8'h4c, 8'h3f);
    rchk(8'h4d, 8'h2f);
    rchk(8'h4f, 8'h00);
    host.wr(8'h4e, 8'h5d);
    rchk(8'h4e, 8'h5d);
    cmp({voltage_scaling_speed, phase_clock_select, switching_frequency_select,
      current_limit_low, switching_mode}, 16'h02ff);
    $display("test mask done");
  endtask
  task automatic t_volt;
    host.wr(8'h4a, 8'h04);
    host.wr(8'h4b, 8'h08);
    @(negedge sys_clk);
    cmp(active_voltage, 16'h1388);
    power_state = 2'h1;
    repeat (2) @(negedge sys_clk);
    cmp({active_setpoint, active_voltage[8:0]}, {7'h08, 9'h170});
    host.wr(8'h4d, 8'h00);
    power_state = 2'h2;
    repeat (2) @(negedge sys_clk);
    cmp({15'h0000, regulator_enable}, 16'h0000);
    host.wr(8'h4d, 8'h20);
    @(negedge sys_clk);
    cmp({14'h0000, regulator_enable, pfm_force}, 16'h0003);
    power_state = 2'h0;
    $display("test voltage done");
  endtask
  task automatic t_range;
    fuse_range_value = 1'b1;
    fuse_range_load = 1'b1;
    @(negedge sys_clk);
    fuse_range_load = 1'b0;
    rchk(8'h4b, 8'h48);
    rchk(8'h4c, 8'h7f);
    host.wr(8'h4a, 8'h00);
    rchk(8'h4a, 8'h40);
    power_state = 2'h2;
    repeat (2) @(negedge sys_clk);
    cmp({8'h00, setpoint_reserved, active_setpoint}, 16'h00ff);
    power_state = 2'h1;
    repeat (2) @(negedge sys_clk);
    cmp(active_voltage, 16'h2ee0);
    power_state = 2'h0;
    $display("test range done");
  endtask
  task automatic summarize;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(negedge sys_clk);
    reset = 1'b0;
    t_reset;
    t_mask;
    t_volt;
    t_range;
    summarize;
  end
endmodule // testbench
`default_nettype wire
